// ---- logic/flash_bus_cycle.v ----
`timescale 1ns/100ps
`include "flash_prot_map.vh"

module flash_bus_cycle #(
    parameter AW = 21,
    parameter DW = 16
) (
    input wire hclk,
    input wire hresetn,
    input wire start,
    input wire is_write,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wdata,
    output reg done,
    output reg [DW-1:0] rdata,
    output reg [AW-1:0] flash_addr,
    output reg [DW-1:0] flash_dq_out,
    output reg flash_dq_oe,
    input wire [DW-1:0] flash_dq_in,
    output reg flash_ce_n,
    output reg flash_oe_n,
    output reg flash_we_n
);
    localparam S_IDLE = 2'd0;
    localparam S_SETUP = 2'd1;
    localparam S_STROBE = 2'd2;
    localparam S_HOLD = 2'd3;
    localparam integer SETUP_N = `SETUP_CYC;
    localparam integer STROBE_N = `STROBE_CYC;

    reg [1:0] state_reg;
    reg [7:0] cnt_reg;
    reg wr_reg;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= S_IDLE;
            cnt_reg <= 8'h00;
            wr_reg <= 1'b0;
            done <= 1'b0;
            rdata <= {DW{1'b0}};
            flash_addr <= {AW{1'b0}};
            flash_dq_out <= {DW{1'b0}};
            flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
        end else begin
            done <= 1'b0;
            case (state_reg)
            S_IDLE: begin
                if (start) begin
                    flash_addr <= addr;
                    flash_dq_out <= wdata;
                    flash_dq_oe <= is_write;
                    wr_reg <= is_write;
                    flash_ce_n <= 1'b0;
                    cnt_reg <= SETUP_N[7:0];
                    state_reg <= S_SETUP;
                end
            end
            S_SETUP: begin
                if (cnt_reg <= 8'h01) begin
                    // Address settles before the strobe to avoid glitch writes
                    flash_we_n <= ~wr_reg;
                    flash_oe_n <= wr_reg;
                    cnt_reg <= STROBE_N[7:0];
                    state_reg <= S_STROBE;
                end else begin
                    cnt_reg <= cnt_reg - 8'h01;
                end
            end
            S_STROBE: begin
                if (cnt_reg <= 8'h01) begin
                    rdata <= flash_dq_in;
                    flash_we_n <= 1'b1;
                    flash_oe_n <= 1'b1;
                    state_reg <= S_HOLD;
                end else begin
                    cnt_reg <= cnt_reg - 8'h01;
                end
            end
            S_HOLD: begin
                flash_ce_n <= 1'b1;
                flash_dq_oe <= 1'b0;
                done <= 1'b1;
                state_reg <= S_IDLE;
            end
            default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule

// ---- logic/flash_prot_ctrl.v ----
// Overview of operation
// - Protect/unprotect use normal writes with elevated voltage on reset.
// - Host protects all unprotected groups before first unprotect write.
// - Lock by entry sequence then protect procedure, any reset level.
// - Host exits secure region before using the rest of the array.
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "flash_prot_map.vh"

module flash_prot_ctrl #(
    parameter AW = 21,
    parameter DW = 16,
    parameter VID_SETTLE = `VID_CYC
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    output reg [AW-1:0] flash_addr,
    output reg [DW-1:0] flash_dq_out,
    output reg flash_dq_oe,
    input wire [DW-1:0] flash_dq_in,
    output reg flash_ce_n,
    output reg flash_oe_n,
    output reg flash_we_n,
    output reg flash_wp_n,
    output reg flash_wp_oe,
    output reg flash_vid_en
);
    localparam S_IDLE = 3'd0;
    localparam S_SEQ = 3'd1;
    localparam S_WAIT = 3'd2;
    localparam S_VID = 3'd3;
    localparam S_DONE = 3'd4;

    reg [2:0] state_reg;
    reg [2:0] cmd_reg;
    reg [AW-1:0] addr_reg;
    reg [DW-1:0] wdata_reg;
    reg [DW-1:0] rdata_reg;
    reg [1:0] step_reg;
    reg [15:0] vid_cnt_reg;
    reg busy_reg;
    reg err_reg;
    reg secmode_reg;
    reg wp_low_reg;
    reg ap_wr_reg;
    reg ap_rd_reg;
    reg [7:0] ap_addr_reg;
    reg start_reg;
    reg cyc_wr_reg;
    reg [AW-1:0] cyc_addr_reg;
    reg [DW-1:0] cyc_data_reg;

    wire cyc_done;
    wire [DW-1:0] cyc_rdata;
    wire [AW-1:0] bc_addr;
    wire [DW-1:0] bc_dq;
    wire bc_oe;
    wire bc_ce_n;
    wire bc_oe_n;
    wire bc_we_n;

    // Autoselect address for a group status read: A6=0, A1=1, A0=0
    function [AW-1:0] grp_query_addr;
        input [AW-1:0] a;
        begin
            grp_query_addr = {a[AW-1:`GRP_ADDR_LSB], {`GRP_ADDR_LSB{1'b0}}}
                | {{(AW-2){1'b0}}, 2'b10};
        end
    endfunction

    // Standard unlock cycle addresses and data
    function [AW+DW-1:0] seq_word;
        input [1:0] step;
        input [7:0] code;
        begin
            case (step)
            2'd0: seq_word = {{(AW-12){1'b0}}, 12'h555, {(DW-8){1'b0}}, 8'haa};
            2'd1: seq_word = {{(AW-12){1'b0}}, 12'h2aa, {(DW-8){1'b0}}, 8'h55};
            default: seq_word = {{(AW-12){1'b0}}, 12'h555,
                {(DW-8){1'b0}}, code};
            endcase
        end
    endfunction

    flash_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(start_reg),
        .is_write(cyc_wr_reg),
        .addr(cyc_addr_reg),
        .wdata(cyc_data_reg),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .flash_addr(bc_addr),
        .flash_dq_out(bc_dq),
        .flash_dq_oe(bc_oe),
        .flash_dq_in(flash_dq_in),
        .flash_ce_n(bc_ce_n),
        .flash_oe_n(bc_oe_n),
        .flash_we_n(bc_we_n)
    );

    wire ctrl_go = ap_wr_reg && ap_addr_reg == `REG_CTRL_OFS
        && hwdata[`CTRL_GO_BIT];
    wire [2:0] go_cmd = hwdata[`CTRL_CMD_MSB:`CTRL_CMD_LSB];
    wire [AW+DW-1:0] seq_cur = seq_word(step_reg,
        cmd_reg == `CMD_SEC_ENTER ? 8'h88 : 8'h90);

    // AHB-Lite slave: zero wait states, always OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_reg <= 1'b0;
            ap_rd_reg <= 1'b0;
            ap_addr_reg <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            ap_wr_reg <= hsel && hready && htrans[1] && hwrite;
            ap_rd_reg <= hsel && hready && htrans[1] && !hwrite;
            if (hsel && hready && htrans[1]) begin
                ap_addr_reg <= haddr[7:0];
            end
            if (hsel && hready && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                `REG_CTRL_OFS: hrdata <= {26'h0, flash_vid_en, wp_low_reg,
                    cmd_reg, 1'b0};
                `REG_ADDR_OFS: hrdata <= {{(32-AW){1'b0}}, addr_reg};
                `REG_WDATA_OFS: hrdata <= {{(32-DW){1'b0}}, wdata_reg};
                `REG_STATUS_OFS: hrdata <= {27'h0, 1'b0, flash_vid_en,
                    secmode_reg, err_reg, busy_reg};
                `REG_RDATA_OFS: hrdata <= {{(32-DW){1'b0}}, rdata_reg};
                `REG_INFO_OFS: hrdata <= {24'h0, rdata_reg[7:0]};
                default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= S_IDLE;
            cmd_reg <= `CMD_READ;
            addr_reg <= {AW{1'b0}};
            wdata_reg <= {DW{1'b0}};
            rdata_reg <= {DW{1'b0}};
            step_reg <= 2'd0;
            vid_cnt_reg <= 16'h0000;
            busy_reg <= 1'b0;
            err_reg <= 1'b0;
            secmode_reg <= 1'b0;
            wp_low_reg <= 1'b0;
            start_reg <= 1'b0;
            cyc_wr_reg <= 1'b0;
            cyc_addr_reg <= {AW{1'b0}};
            cyc_data_reg <= {DW{1'b0}};
            flash_vid_en <= 1'b0;
            flash_wp_n <= 1'b1;
            flash_wp_oe <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            if (ap_wr_reg && ap_addr_reg == `REG_ADDR_OFS) begin
                addr_reg <= hwdata[AW-1:0];
            end
            if (ap_wr_reg && ap_addr_reg == `REG_WDATA_OFS) begin
                wdata_reg <= hwdata[DW-1:0];
            end
            if (ap_wr_reg && ap_addr_reg == `REG_CTRL_OFS) begin
                // Released pin floats high via the device pull-up
                wp_low_reg <= hwdata[`CTRL_WP_LOW_BIT];
                flash_wp_oe <= hwdata[`CTRL_WP_LOW_BIT];
                flash_wp_n <= 1'b0;
            end
            case (state_reg)
            S_IDLE: begin
                if (ctrl_go) begin
                    cmd_reg <= go_cmd;
                    busy_reg <= 1'b1;
                    err_reg <= 1'b0;
                    step_reg <= 2'd0;
                    case (go_cmd)
                    `CMD_READ, `CMD_WRITE: begin
                        start_reg <= 1'b1;
                        cyc_wr_reg <= go_cmd == `CMD_WRITE;
                        cyc_addr_reg <= addr_reg;
                        cyc_data_reg <= wdata_reg;
                        state_reg <= S_WAIT;
                    end
                    `CMD_GRP_STATUS, `CMD_SEC_ENTER: state_reg <= S_SEQ;
                    `CMD_SEC_EXIT: state_reg <= S_SEQ;
                    `CMD_VID_ON, `CMD_VID_OFF: begin
                        // Hold off cycles while the reset pin voltage settles
                        flash_vid_en <= go_cmd == `CMD_VID_ON;
                        vid_cnt_reg <= VID_SETTLE[15:0];
                        state_reg <= S_VID;
                    end
                    default: begin
                        err_reg <= 1'b1;
                        busy_reg <= 1'b0;
                    end
                    endcase
                end
            end
            S_SEQ: begin
                start_reg <= 1'b1;
                cyc_wr_reg <= 1'b1;
                cyc_addr_reg <= seq_cur[AW+DW-1:DW];
                cyc_data_reg <= seq_cur[DW-1:0];
                if (cmd_reg == `CMD_SEC_EXIT && step_reg == 2'd2) begin
                    cyc_data_reg <= {{(DW-8){1'b0}}, 8'h90};
                end
                if (cmd_reg == `CMD_SEC_EXIT && step_reg == 2'd3) begin
                    cyc_addr_reg <= {AW{1'b0}};
                    cyc_data_reg <= {DW{1'b0}};
                end
                if (cmd_reg == `CMD_GRP_STATUS && step_reg == 2'd3) begin
                    cyc_wr_reg <= 1'b0;
                    cyc_addr_reg <= grp_query_addr(addr_reg);
                end
                state_reg <= S_WAIT;
            end
            S_WAIT: begin
                if (cyc_done) begin
                    rdata_reg <= cyc_rdata;
                    if (cmd_reg == `CMD_GRP_STATUS
                        || cmd_reg == `CMD_SEC_EXIT) begin
                        if (step_reg == 2'd3) begin
                            state_reg <= S_DONE;
                        end else begin
                            step_reg <= step_reg + 2'd1;
                            state_reg <= S_SEQ;
                        end
                    end else if (cmd_reg == `CMD_SEC_ENTER) begin
                        if (step_reg == 2'd2) begin
                            secmode_reg <= 1'b1;
                            state_reg <= S_DONE;
                        end else begin
                            step_reg <= step_reg + 2'd1;
                            state_reg <= S_SEQ;
                        end
                    end else begin
                        state_reg <= S_DONE;
                    end
                end
            end
            S_VID: begin
                if (vid_cnt_reg <= 16'h0001) begin
                    state_reg <= S_DONE;
                end else begin
                    vid_cnt_reg <= vid_cnt_reg - 16'h0001;
                end
            end
            S_DONE: begin
                if (cmd_reg == `CMD_SEC_EXIT) begin
                    secmode_reg <= 1'b0;
                end
                busy_reg <= 1'b0;
                state_reg <= S_IDLE;
            end
            default: state_reg <= S_IDLE;
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_addr <= {AW{1'b0}};
            flash_dq_out <= {DW{1'b0}};
            flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
        end else begin
            flash_addr <= bc_addr;
            flash_dq_out <= bc_dq;
            flash_dq_oe <= bc_oe;
            flash_ce_n <= bc_ce_n;
            flash_oe_n <= bc_oe_n;
            flash_we_n <= bc_we_n;
        end
    end
endmodule

// ---- logic/flash_prot_map.vh ----
`ifndef FLASH_PROT_MAP_VH
`define FLASH_PROT_MAP_VH

// Register offsets (byte addresses on the AHB-Lite slave)
`define REG_CTRL_OFS 8'h00
`define REG_ADDR_OFS 8'h04
`define REG_WDATA_OFS 8'h08
`define REG_STATUS_OFS 8'h0c
`define REG_RDATA_OFS 8'h10
`define REG_INFO_OFS 8'h14

// Control register fields
`define CTRL_GO_BIT 0
`define CTRL_CMD_LSB 1
`define CTRL_CMD_MSB 3
`define CTRL_WP_LOW_BIT 4
`define CTRL_VID_BIT 5

// Commands placed in the command field
`define CMD_READ 3'h0
`define CMD_WRITE 3'h1
`define CMD_GRP_STATUS 3'h2
`define CMD_SEC_ENTER 3'h3
`define CMD_SEC_EXIT 3'h4
`define CMD_VID_ON 3'h5
`define CMD_VID_OFF 3'h6

// Status register fields
`define STAT_BUSY_BIT 0
`define STAT_ERR_BIT 1
`define STAT_SECMODE_BIT 2
`define STAT_VID_BIT 3
`define STAT_ALLPROT_BIT 4

// Indicator bit position in an autoselect read
`define IND_BIT 7

// Bus cycle timing: strobe low time, setup, reset pin voltage settle
`define T_STROBE_NS 70
`define T_SETUP_NS 30
`define T_VID_NS 500
`define CLK_NS 10
`define STROBE_CYC ((`T_STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define SETUP_CYC ((`T_SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define VID_CYC ((`T_VID_NS + `CLK_NS - 1) / `CLK_NS)

// Sector groups
`define NUM_GROUPS 22
`define GRP_ADDR_MSB 20
`define GRP_ADDR_LSB 15

`endif

// ---- verification/flash_dev_model.sv ----
`timescale 1ns/100ps
module flash_dev_model #(
    parameter [21:0] PROT_INIT = 22'h000000,
    parameter [0:0] IND = 1'b0
) (
    input wire [20:0] flash_addr,
    input wire [15:0] flash_dq_out,
    output wire [15:0] flash_dq_in,
    input wire flash_ce_n,
    input wire flash_oe_n,
    input wire flash_we_n
);
    // Stored group states survive any controller reset
    reg [21:0] prot = PROT_INIT;
    reg [1:0] unl = 2'd0;
    reg auto_mode = 1'b0;
    reg sec_mode = 1'b0;
    reg [15:0] last = 16'h0000;
    wire [7:0] d = flash_dq_out[7:0];
    function [4:0] grp(input [5:0] s);
        grp = (s < 6'd4) ? s[4:0] : (s > 6'd59) ? s[4:0] - 5'd10 :
            s[5:2] + 5'd3;
    endfunction
    wire [4:0] g = grp(flash_addr[20:15]);
    wire [15:0] id_val =
        (flash_addr[1:0] == 2'd2) ? {15'h0000, prot[g]} :
        (flash_addr[1:0] == 2'd3) ? {8'h00, IND, 7'h08} :
        16'h0000;
    // Serial number in the low 8 words of every 128; the rest of the locked region reads as blank
    wire [15:0] sec_val = (flash_addr[6:0] < 7'h08) ?
        {8'h5e, flash_addr[7:0]} : 16'hffff;
    wire [15:0] val = auto_mode ? id_val :
        (sec_mode && flash_addr[20:15] == 6'd0) ? sec_val :
        {8'ha5, flash_addr[7:0]};
    // Released bus shows the inverse of the last value, never a stale copy
    assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? val : ~last;
    always @(posedge flash_oe_n) begin
        last <= val;
    end
    always @(posedge flash_we_n) begin
        if (!flash_ce_n) begin
            if (unl == 2'd0 && d == 8'haa) begin
                unl <= 2'd1;
            end else if (unl == 2'd1 && d == 8'h55) begin
                unl <= 2'd2;
            end else if (unl == 2'd2) begin
                unl <= 2'd0;
                auto_mode <= (d == 8'h90);
                if (d == 8'h88) begin
                    sec_mode <= 1'b1;
                end
            end else begin
                unl <= 2'd0;
                if (auto_mode && d == 8'h00) begin
                    auto_mode <= 1'b0;
                    sec_mode <= 1'b0;
                end
            end
        end
    end
endmodule

// ---- verification/flash_prot_ctrl_chk.sv ----
`timescale 1ns/100ps
module flash_prot_ctrl_chk #(
    parameter AW = 21
) (
    input wire hclk,
    input wire hresetn,
    input wire hreadyout,
    input wire hresp,
    input wire [AW-1:0] flash_addr,
    input wire flash_dq_oe,
    input wire flash_ce_n,
    input wire flash_oe_n,
    input wire flash_we_n,
    input wire flash_wp_n,
    input wire flash_wp_oe
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("response not OKAY");
    ready_high_a: assert property (hreadyout == 1'b1)
        else $error("wait state inserted");
    we_ce_a: assert property ($fell(flash_we_n)
        |-> $past(!flash_ce_n))
        else $error("write strobe without prior chip select");
    we_width_a: assert property ($fell(flash_we_n)
        |=> !flash_we_n [*6])
        else $error("write strobe too short");
    addr_stable_a: assert property (
        !flash_we_n && $past(!flash_we_n) |-> $stable(flash_addr))
        else $error("address moved under write strobe");
    strobe_excl_a: assert property (
        !(flash_we_n == 1'b0 && flash_oe_n == 1'b0))
        else $error("read and write strobes together");
    read_release_a: assert property (!flash_oe_n |-> !flash_dq_oe)
        else $error("data driven during read");
    wp_low_a: assert property (flash_wp_oe |-> !flash_wp_n)
        else $error("protect pin driven high");
endmodule
bind flash_prot_ctrl flash_prot_ctrl_chk #(.AW(AW)) flash_prot_ctrl_chk_inst (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_wp_n(flash_wp_n), .flash_wp_oe(flash_wp_oe));

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
`include "flash_prot_map.vh"
module testbench;
    reg hclk, hresetn, hsel, hwrite;
    reg [31:0] haddr, hwdata;
    reg [1:0] htrans;
    reg [2:0] hsize;
    wire hreadyout, hresp, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
    wire flash_wp_n, flash_wp_oe, flash_vid_en;
    wire [31:0] hrdata;
    wire [20:0] flash_addr;
    wire [15:0] flash_dq_out, flash_dq_in;
    wire wp_pin = flash_wp_oe ? flash_wp_n : 1'b1;
    integer n_errors, n_checks;
    reg [31:0] rd;
    flash_prot_ctrl #(.AW(21), .DW(16), .VID_SETTLE(4)) flash_prot_ctrl_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
        .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .flash_wp_n(flash_wp_n),
        .flash_wp_oe(flash_wp_oe), .flash_vid_en(flash_vid_en));
    flash_dev_model #(.PROT_INIT(22'h000010), .IND(1'b1))
        flash_dev_model_inst (
        .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
        .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task print_verdict;
        begin
            $display("checks %0d errors %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wait_rdy;
        integer k;
        begin
            k = 0;
            @(posedge hclk);
            while (hreadyout !== 1'b1) begin
                k = k + 1;
                if (k > 100) begin
                    n_errors = n_errors + 1;
                    print_verdict;
                end
                @(posedge hclk);
            end
        end
    endtask
    task ahb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge hclk);
            hsel <= 1'b1;
            htrans <= 2'b10;
            hwrite <= w;
            haddr <= {24'h000000, a};
            wait_rdy;
            htrans <= 2'b00;
            hwdata <= d;
            wait_rdy;
            rd = hrdata;
        end
    endtask
    // Busy rises on the clock edge that completes the GO write; wait four cycles, then poll
    task run_cmd(input [2:0] c, input wp);
        integer k;
        begin
            ahb(1'b1, `REG_CTRL_OFS, {27'h0, wp, c, 1'b1});
            repeat (4) @(posedge hclk);
            k = 0;
            rd = 32'h1;
            while (rd[`STAT_BUSY_BIT] !== 1'b0) begin
                k = k + 1;
                if (k > 200) begin
                    n_errors = n_errors + 1;
                    print_verdict;
                end
                ahb(1'b0, `REG_STATUS_OFS, 32'h0);
            end
        end
    endtask
    task test_reset;
        begin
            ahb(1'b0, `REG_STATUS_OFS, 32'h0);
            chk(rd, 32'h0);
            ahb(1'b0, 8'h20, 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, flash_wp_oe}, 32'h0);
        end
    endtask
    task read_at(input [20:0] a);
        begin
            ahb(1'b1, `REG_ADDR_OFS, {11'h000, a});
            run_cmd(`CMD_READ, 1'b0);
            ahb(1'b0, `REG_RDATA_OFS, 32'h0);
        end
    endtask
    task test_secure;
        begin
            run_cmd(`CMD_SEC_ENTER, 1'b0);
            chk({31'h0, rd[`STAT_SECMODE_BIT]}, 32'h1);
            read_at(21'h000005);
            chk(rd & 32'hffff, 32'h5e05);
            read_at(21'h000009);
            chk(rd & 32'hffff, 32'hffff);
            run_cmd(`CMD_SEC_EXIT, 1'b0);
            chk({31'h0, rd[`STAT_SECMODE_BIT]}, 32'h0);
            read_at(21'h000005);
            chk(rd & 32'hffff, 32'ha505);
        end
    endtask
    task test_groups;
        integer i;
        reg [5:0] sect [0:3];
        reg [31:0] exp [0:3];
        begin
            sect[0] = 6'd5; exp[0] = 32'h1;
            sect[1] = 6'd6; exp[1] = 32'h1;
            sect[2] = 6'd3; exp[2] = 32'h0;
            sect[3] = 6'd60; exp[3] = 32'h0;
            for (i = 0; i < 4; i = i + 1) begin
                ahb(1'b1, `REG_ADDR_OFS, {11'h000, sect[i], 15'h0000});
                run_cmd(`CMD_GRP_STATUS, 1'b0);
                ahb(1'b0, `REG_RDATA_OFS, 32'h0);
                chk(rd & 32'h1, exp[i]);
            end
            read_at(21'h000003);
            ahb(1'b0, `REG_INFO_OFS, 32'h0);
            chk(rd & 32'hff, 32'h88);
        end
    endtask
    // A plain write of the reset code leaves query mode, so array reads return
    task test_write;
        begin
            ahb(1'b1, `REG_WDATA_OFS, 32'h0);
            ahb(1'b1, `REG_ADDR_OFS, 32'h0);
            run_cmd(`CMD_WRITE, 1'b0);
            chk({31'h0, rd[`STAT_ERR_BIT]}, 32'h0);
            read_at(21'h000003);
            chk(rd & 32'hffff, 32'ha503);
        end
    endtask
    task test_vid;
        begin
            run_cmd(`CMD_VID_ON, 1'b0);
            chk({31'h0, flash_vid_en}, 32'h1);
            chk({31'h0, rd[`STAT_VID_BIT]}, 32'h1);
            run_cmd(`CMD_VID_OFF, 1'b0);
            chk({31'h0, flash_vid_en}, 32'h0);
        end
    endtask
    task test_wp_err;
        begin
            run_cmd(3'h7, 1'b1);
            chk({31'h0, rd[`STAT_ERR_BIT]}, 32'h1);
            chk({31'h0, wp_pin}, 32'h0);
            ahb(1'b1, `REG_CTRL_OFS, 32'h0);
            repeat (3) @(posedge hclk);
            chk({31'h0, wp_pin}, 32'h1);
        end
    endtask
    initial begin
        n_errors = 0;
        n_checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hsize = 3'h2;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset;
        test_secure;
        test_groups;
        test_write;
        test_vid;
        test_wp_err;
        print_verdict;
    end
endmodule
